//--- regfile_pkg.sv
package regfile_pkg;

    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int GROUP_W   = 4;
    localparam int REG_IDX_W = 4;
    localparam int PAGE_W    = 6;
    localparam int NUM_PAGES = 64;
    localparam int NUM_LOCAL = 240;

    localparam logic [GROUP_W-1:0] GROUP_D = 4'hd;
    localparam logic [GROUP_W-1:0] GROUP_F = 4'hf;

    localparam logic [ADDR_W-1:0] PORT0_DATA_ADDR     = 8'he0;
    localparam logic [ADDR_W-1:0] PORT1_DATA_ADDR     = 8'he1;
    localparam logic [ADDR_W-1:0] PORT2_DATA_ADDR     = 8'he2;
    localparam logic [ADDR_W-1:0] PORT3_DATA_ADDR     = 8'he3;
    localparam logic [ADDR_W-1:0] PORT4_DATA_ADDR     = 8'he4;
    localparam logic [ADDR_W-1:0] PORT5_DATA_ADDR     = 8'he5;
    localparam logic [ADDR_W-1:0] CENTRAL_INT_ADDR    = 8'he6;
    localparam logic [ADDR_W-1:0] FLAGS_ADDR          = 8'he7;
    localparam logic [ADDR_W-1:0] WORK_PTR_A_ADDR     = 8'he8;
    localparam logic [ADDR_W-1:0] WORK_PTR_B_ADDR     = 8'he9;
    localparam logic [ADDR_W-1:0] PAGE_SELECT_ADDR    = 8'hea;
    localparam logic [ADDR_W-1:0] CORE_MODE_ADDR      = 8'heb;
    localparam logic [ADDR_W-1:0] USER_SP_HIGH_ADDR   = 8'hec;
    localparam logic [ADDR_W-1:0] USER_SP_LOW_ADDR    = 8'hed;
    localparam logic [ADDR_W-1:0] SYSTEM_SP_HIGH_ADDR = 8'hee;
    localparam logic [ADDR_W-1:0] SYSTEM_SP_LOW_ADDR  = 8'hef;

    // pointer layout: bit 0 of pointer a selects two eight-register blocks
    localparam int SPLIT_BIT = 0;
    localparam int BLK16_LSB = 4;
    localparam int BLK8_LSB  = 3;

    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] EMPTY_READ = 8'h00;

    typedef enum {
        ST_IDLE,
        ST_PAGE_WAIT
    } seq_state_t;

    function automatic logic [GROUP_W-1:0] addr_group(
        input logic [ADDR_W-1:0] a
    );
        return a[ADDR_W-1:ADDR_W-GROUP_W];
    endfunction : addr_group

endpackage : regfile_pkg

//--- resolve_if.sv
`timescale 1ns/1ps
`default_nettype none

interface resolve_if;
    import regfile_pkg::*;

    logic              working;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] ptr_a;
    logic [DATA_W-1:0] ptr_b;
    logic [ADDR_W-1:0] phys;
    logic              blocked;
    logic              paged;

    modport core (
        output working,
        output addr,
        output ptr_a,
        output ptr_b,
        input  phys,
        input  blocked,
        input  paged
    );

    modport resolver (
        input  working,
        input  addr,
        input  ptr_a,
        input  ptr_b,
        output phys,
        output blocked,
        output paged
    );

endinterface : resolve_if

`default_nettype wire

//--- operand_resolver.sv
`timescale 1ns/1ps
`default_nettype none

module operand_resolver
    import regfile_pkg::*;
(
    resolve_if.resolver r
);

    logic [REG_IDX_W-1:0] idx;

    always_comb begin
        idx = r.addr[REG_IDX_W-1:0];
        if (r.working) begin
            // four-bit index, sixteen working registers
            r.blocked = 1'b0;
            if (!r.ptr_a[SPLIT_BIT]) begin
                // one block on a 16-byte boundary
                r.phys = {r.ptr_a[ADDR_W-1:BLK16_LSB], idx};
            end else if (!idx[BLK8_LSB]) begin
                // two blocks, each on an 8-byte boundary
                r.phys = {r.ptr_a[ADDR_W-1:BLK8_LSB], idx[BLK8_LSB-1:0]};
            end else begin
                r.phys = {r.ptr_b[ADDR_W-1:BLK8_LSB], idx[BLK8_LSB-1:0]};
            end
        end else begin
            // one physical register per address value
            r.phys    = r.addr;
            r.blocked = (addr_group(r.addr) == GROUP_D);
        end
        // group e and f reached in either mode
        r.paged = (addr_group(r.phys) == GROUP_F);
    end

endmodule : operand_resolver

`default_nettype wire

//--- register_file_addressing.sv
//
// Overview of operation
// - direct 8-bit address reaches every group except D, one register each
// - direct access to group d is refused; only working mode reaches it
// - working operand is a 4-bit index, 0 to 15, resolved through pointers
// - working window is one block of sixteen or two blocks of eight
// - blocks start on 16-byte or 8-byte boundaries set by the pointers
// - system registers 224-239 reachable in direct and working modes
// - group f is a window onto up to 64 pages of 16 registers
// - page select register at 234 chooses the page seen in group f
// - page stays mapped until page select is rewritten
// - n-th group f location reaches n-th register of the selected page
// - peripheral registers keep fixed page and register positions
// - page exists only when its peripheral is present
`timescale 1ns/1ps
`default_nettype none

module register_file_addressing
    import regfile_pkg::*;
#(
    parameter logic [NUM_PAGES-1:0] PAGES_PRESENT = {NUM_PAGES{1'b1}}
) (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic              acc_valid_i,
    input  wire logic              acc_write_i,
    input  wire logic              acc_working_i,
    input  wire logic [ADDR_W-1:0] acc_addr_i,
    input  wire logic [DATA_W-1:0] acc_wdata_i,
    output logic                   acc_ready_o,
    output logic [DATA_W-1:0]      acc_rdata_o,
    output logic                   acc_rvalid_o,
    output logic                   acc_refused_o,
    output logic [PAGE_W-1:0]      periph_page_o,
    output logic [REG_IDX_W-1:0]   periph_reg_o,
    output logic [DATA_W-1:0]      periph_wdata_o,
    output logic                   periph_wr_o,
    output logic                   periph_rd_o,
    input  wire logic [DATA_W-1:0] periph_rdata_i
);

    typedef struct packed {
        logic [NUM_LOCAL-1:0][DATA_W-1:0] mem;
        seq_state_t                       state;
        logic                             ready;
        logic [DATA_W-1:0]                rdata;
        logic                             rvalid;
        logic                             refused;
        logic [PAGE_W-1:0]                p_page;
        logic [REG_IDX_W-1:0]             p_reg;
        logic [DATA_W-1:0]                p_wdata;
        logic                             p_wr;
        logic                             p_rd;
    } core_state_t;

    core_state_t st_ff;
    core_state_t nxt_st;

    resolve_if rs ();

    operand_resolver u_resolver (
        .r (rs.resolver)
    );

    logic [PAGE_W-1:0] cur_page;
    logic              page_ok;

    // pointers live in the register file itself, so a write is seen at once
    assign rs.working = acc_working_i;
    assign rs.addr    = acc_addr_i;
    assign rs.ptr_a   = st_ff.mem[WORK_PTR_A_ADDR];
    assign rs.ptr_b   = st_ff.mem[WORK_PTR_B_ADDR];

    // page held until page select is written again
    assign cur_page = st_ff.mem[PAGE_SELECT_ADDR][PAGE_W-1:0];
    assign page_ok  = PAGES_PRESENT[cur_page];

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rvalid  = 1'b0;
        nxt_st.refused = 1'b0;
        nxt_st.p_wr    = 1'b0;
        nxt_st.p_rd    = 1'b0;
        unique case (st_ff.state)
            ST_IDLE: begin
                if (acc_valid_i && st_ff.ready) begin
                    if (rs.blocked) begin
                        // dropped write, zero on read
                        nxt_st.refused = 1'b1;
                        if (!acc_write_i) begin
                            nxt_st.rdata  = EMPTY_READ;
                            nxt_st.rvalid = 1'b1;
                        end
                    end else if (rs.paged) begin
                        if (page_ok) begin
                            // fixed page and offset, no remap
                            nxt_st.p_page  = cur_page;
                            nxt_st.p_reg   = rs.phys[REG_IDX_W-1:0];
                            nxt_st.p_wdata = acc_wdata_i;
                            if (acc_write_i) begin
                                nxt_st.p_wr = 1'b1;
                            end else begin
                                // peripheral answers one cycle later
                                nxt_st.p_rd  = 1'b1;
                                nxt_st.ready = 1'b0;
                                nxt_st.state = ST_PAGE_WAIT;
                            end
                        end else if (!acc_write_i) begin
                            // absent page reads as zero
                            nxt_st.rdata  = EMPTY_READ;
                            nxt_st.rvalid = 1'b1;
                        end
                    end else if (acc_write_i) begin
                        nxt_st.mem[rs.phys] = acc_wdata_i;
                    end else begin
                        nxt_st.rdata  = st_ff.mem[rs.phys];
                        nxt_st.rvalid = 1'b1;
                    end
                end
            end
            ST_PAGE_WAIT: begin
                nxt_st.rdata  = periph_rdata_i;
                nxt_st.rvalid = 1'b1;
                nxt_st.ready  = 1'b1;
                nxt_st.state  = ST_IDLE;
            end
        endcase
        if (reset_i) begin
            nxt_st         = '0;
            nxt_st.mem     = {NUM_LOCAL{RESET_BYTE}};
            nxt_st.state   = ST_IDLE;
            nxt_st.ready   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st_ff <= nxt_st;
    end

    assign acc_ready_o    = st_ff.ready;
    assign acc_rdata_o    = st_ff.rdata;
    assign acc_rvalid_o   = st_ff.rvalid;
    assign acc_refused_o  = st_ff.refused;
    assign periph_page_o  = st_ff.p_page;
    assign periph_reg_o   = st_ff.p_reg;
    assign periph_wdata_o = st_ff.p_wdata;
    assign periph_wr_o    = st_ff.p_wr;
    assign periph_rd_o    = st_ff.p_rd;

endmodule : register_file_addressing

`default_nettype wire

//--- regfile_pkg_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- register_file_addressing_checker.sv
`timescale 1ns/1ps
`default_nettype none
module register_file_addressing_checker
    import regfile_pkg::*;
(
    input wire logic                 sys_clk_i,
    input wire logic                 reset_i,
    input wire logic                 acc_valid_i,
    input wire logic                 acc_write_i,
    input wire logic                 acc_working_i,
    input wire logic [ADDR_W-1:0]    acc_addr_i,
    input wire logic                 acc_ready_o,
    input wire logic                 acc_rvalid_o,
    input wire logic                 acc_refused_o,
    input wire logic                 periph_rd_o,
    input wire logic                 periph_wr_o,
    input wire logic [REG_IDX_W-1:0] periph_reg_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire logic       tk = acc_valid_i && acc_ready_o;
    wire logic       dr = tk && !acc_working_i;
    wire logic       tw = tk && acc_write_i;
    wire logic [3:0] g  = acc_addr_i[7:4];
    sequence slow_answer;
        !acc_ready_o ##1 (acc_ready_o && acc_rvalid_o);
    endsequence
    grp_d_refuse_a: assert property (dr && g == GROUP_D
        |=> acc_refused_o) else $error("group d not refused");
    work_ok_a: assert property (tk && acc_working_i |=> !acc_refused_o)
        else $error("working access refused");
    work_rd_a: assert property (tk && acc_working_i && !acc_write_i
        |-> ##[1:2] acc_rvalid_o) else $error("working read lost");
    local_rd_a: assert property (dr && !acc_write_i && g < GROUP_F
        |=> acc_rvalid_o && !periph_rd_o) else $error("local read wrong");
    paged_rd_a: assert property (dr && !acc_write_i && g == GROUP_F
        |=> acc_rvalid_o
            || (periph_rd_o && {GROUP_F, periph_reg_o} == $past(acc_addr_i)))
        else $error("paged read wrong");
    rd_wait_a: assert property (periph_rd_o |-> slow_answer)
        else $error("paged read answer late");
    sys_grp_a: assert property (dr && g == 4'he
        |=> !periph_rd_o && !periph_wr_o && !acc_refused_o)
        else $error("system access wrong");
    wr_src_a: assert property (periph_wr_o |-> $past(tw))
        else $error("stray peripheral write");
endmodule : register_file_addressing_checker
`default_nettype wire

//--- periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rd_i,
    input  wire logic [5:0] page_i,
    input  wire logic [3:0] reg_i,
    output logic      [7:0] rdata_o
);
    // idle bus churns so a mistimed sample cannot pass
    logic [7:0] spin_ff = 8'h00;
    always_ff @(posedge sys_clk_i) begin
        spin_ff <= spin_ff + 8'h3b;
    end
    // every page bit shapes the answer, so a one-bit page error shows up
    assign rdata_o = rd_i ? {page_i[3:0] ^ {page_i[5:4], 2'h0}, reg_i} ^ 8'ha5
                          : spin_ff;
endmodule : periph_model
`default_nettype wire

//--- register_file_addressing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module register_file_addressing_bench;
    import regfile_pkg::*;
    logic              sys_clk_i, reset_i, acc_valid_i, acc_write_i;
    logic              acc_working_i, acc_ready_o, acc_rvalid_o, acc_refused_o;
    logic              periph_wr_o, periph_rd_o, rf, pw;
    logic [ADDR_W-1:0] acc_addr_i;
    logic [DATA_W-1:0] acc_wdata_i, acc_rdata_o, periph_wdata_o, periph_rdata_i;
    logic [DATA_W-1:0] got, wd, a, d, p, v, mem [256];
    logic [DATA_W-1:0] corner [4] = '{8'hcf, 8'hd0, 8'hdf, 8'hef};
    logic [PAGE_W-1:0] periph_page_o, pg;
    logic [3:0]        periph_reg_o, pr;
    int                fail_count = 0, cmp_count = 0;
    // page 63 left out to see an absent page
    register_file_addressing #(.PAGES_PRESENT({1'b0, {63{1'b1}}}))
        i_register_file_addressing (.*);
    periph_model i_periph_model (.sys_clk_i(sys_clk_i), .rd_i(periph_rd_o),
        .page_i(periph_page_o), .reg_i(periph_reg_o), .rdata_o(periph_rdata_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [7:0] wphys(input logic [7:0] pa, pb,
                                         input logic [3:0] x);
        if (!pa[0]) return {pa[7:4], x};
        return {(x[3] ? pb[7:3] : pa[7:3]), x[2:0]};
    endfunction : wphys
    function automatic logic [7:0] pexp(input logic [5:0] pn,
                                        input logic [3:0] r);
        return {pn[3:0] ^ {pn[5:4], 2'h0}, r} ^ 8'ha5;
    endfunction : pexp
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [7:0] gv, ev);
        cmp_count++;
        if (gv !== ev) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, gv, ev);
        end
    endtask : check
    // request held from a falling edge until the edge that takes it
    task automatic acc(input logic w, k, input logic [7:0] ad, dd);
        int n;
        @(negedge sys_clk_i);
        {acc_valid_i, acc_write_i, acc_working_i} = {1'b1, w, k};
        {acc_addr_i, acc_wdata_i} = {ad, dd};
        n = 0;
        while (acc_ready_o !== 1'b1 && n < 9) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(negedge sys_clk_i);
        acc_valid_i = 1'b0;
        {rf, pw, pg, pr, wd} = {acc_refused_o, periph_wr_o, periph_page_o,
                                periph_reg_o, periph_wdata_o};
        while (!w && acc_rvalid_o !== 1'b1 && n < 9) begin
            @(negedge sys_clk_i);
            n++;
        end
        got = acc_rdata_o;
        if (n >= 9) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : acc
    initial begin
        {acc_valid_i, acc_write_i, acc_working_i, acc_addr_i, acc_wdata_i} = '0;
        reset_i = 1'b1;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(32'h8061));
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        // group boundaries first, then random over groups 0 to e
        for (int i = 0; i < 40; i++) begin
            a = i < 4 ? corner[i] : 8'($urandom_range(0, 239));
            d = 8'($urandom);
            acc(1'b1, 1'b0, a, d);
            if (a[7:4] != 4'hd) mem[a] = d;
            acc(1'b0, 1'b0, a, 8'h00);
            check(got, mem[a]);
            check({7'h0, rf}, {7'h0, a[7:4] == 4'hd});
        end
        // one block in group d, two split blocks, split into system group
        for (int s = 0; s < 3; s++) begin
            a = s == 0 ? 8'hd0 : s == 1 ? 8'h21 : 8'hb9;
            d = s == 0 ? 8'h00 : s == 1 ? 8'h48 : 8'he1;
            acc(1'b1, 1'b0, WORK_PTR_A_ADDR, a);
            acc(1'b1, 1'b0, WORK_PTR_B_ADDR, d);
            for (int x = 0; x < 16; x++) begin
                p = wphys(a, d, 4'(x));
                v = 8'($urandom);
                acc(1'b1, 1'b1, 8'(x), v);
                acc(1'b0, 1'b1, 8'(x), 8'h00);
                check(got, v);
                acc(1'b0, 1'b0, p, 8'h00);
                check(got, p[7:4] == 4'hd ? 8'h00 : v);
            end
        end
        // page 5, page 62 with top bits set, then absent page 63
        for (int s = 0; s < 3; s++) begin
            a = s == 0 ? 8'h05 : s == 1 ? 8'h7e : 8'hff;
            v = 8'($urandom);
            acc(1'b1, 1'b0, PAGE_SELECT_ADDR, a);
            acc(1'b1, 1'b0, 8'hf2, v);
            if (s < 2) check({2'h0, pg}, {2'h0, a[5:0]});
            if (s < 2) check({pr, pw, 3'h0}, 8'h28);
            if (s < 2) check(wd, v);
            if (s == 2) check({7'h0, pw}, 8'h00);
            for (int x = 0; x < 16; x++) begin
                acc(1'b0, 1'b0, {4'hf, 4'(x)}, 8'h00);
                check(got, s == 2 ? 8'h00 : pexp(a[5:0], 4'(x)));
            end
        end
        // working block over group f still goes through the page
        acc(1'b1, 1'b0, WORK_PTR_A_ADDR, 8'hf0);
        acc(1'b1, 1'b0, PAGE_SELECT_ADDR, 8'h05);
        acc(1'b0, 1'b1, 8'h04, 8'h00);
        check(got, pexp(6'h05, 4'h4));
        // mid-run reset clears the file, the pointers and the page choice
        acc(1'b1, 1'b0, 8'h10, 8'h5a);
        reset_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        reset_i = 1'b0;
        acc(1'b0, 1'b0, 8'h10, 8'h00);
        check(got, 8'h00);
        acc(1'b0, 1'b1, 8'hf3, 8'h00);
        check(got, 8'h00);
        acc(1'b0, 1'b0, 8'hf3, 8'h00);
        check(got, pexp(6'h00, 4'h3));
        tally_and_finish();
    end
endmodule : register_file_addressing_bench
bind register_file_addressing register_file_addressing_checker
    i_register_file_addressing_checker (.*);
`default_nettype wire
